// [logic/host_bus_interface_config.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Sync family-one mode: fixed timing, no ready
// - Family-one modes: separate data, 11-bit address
// - Family-one modes: decoder off, chip select used
// - Async family-one mode: drive acknowledge per access
// - Sync family-zero: multiplexed bus, no ready
// - Sync family-zero: latch low address on strobe
// - Internal decoder selects on pattern 00000xxxb
// - Async family-zero: separate buses, ready paces access
// - Family-one: swap bytes of 16-bit registers
// - Divided clock: by two high, four low
// - Host wins shared RAM over sequencer
module host_bus_interface_config (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic                            host_family_select,
  input  wire logic                            timing_mode_select,
  input  wire logic                            divider_select,
  input  wire logic                            chip_select_n,
  input  wire logic [host_bus_pkg::ADDR_W-1:0] address_bus_in,
  input  wire logic                            addr_latch_strobe,
  input  wire logic                            read_or_direction_in,
  input  wire logic                            write_or_strobe_in,
  input  wire logic [host_bus_pkg::DATA_W-1:0] data_bus_io_in,
  output var  logic [host_bus_pkg::DATA_W-1:0] data_bus_io_out,
  output var  logic                            data_bus_io_oe,
  output var  logic                            host_ready_out,
  output var  logic                            transfer_ack_out,
  output var  logic                            divided_clock_out,
  input  wire logic                            seq_req,
  input  wire logic                            seq_we,
  input  wire logic [host_bus_pkg::ADDR_W-1:0] seq_addr,
  input  wire logic [host_bus_pkg::DATA_W-1:0] seq_wdata,
  output var  logic [host_bus_pkg::DATA_W-1:0] seq_rdata,
  output var  logic                            seq_done
);
  import host_bus_pkg::*;

  // ==========================================================
  // Decoding helpers
  function automatic logic strobe_on(input logic mot, input logic rd, input logic wr);
    strobe_on = mot ? wr : (!rd || !wr);
  endfunction

  function automatic logic is_read(input logic mot, input logic rd);
    is_read = mot ? rd : !rd;
  endfunction

  // ==========================================================
  // State
  logic                  mot_reg;
  logic                  sync_reg;
  bus_state_t            state_reg;
  bus_state_t            state_next;
  logic [7:0]            latch_reg;
  logic [7:0]            latch_next;
  logic [ADDR_W-1:0]     addr_reg;
  logic [ADDR_W-1:0]     addr_next;
  logic                  rd_reg;
  logic                  rd_next;
  logic [DATA_W-1:0]     wdata_reg;
  logic [DATA_W-1:0]     wdata_next;
  logic [DATA_W-1:0]     dout_next;
  logic                  oe_next;
  logic                  rdy_next;
  logic                  ack_next;
  logic [DATA_W-1:0]     seq_rdata_next;
  logic                  seq_done_next;
  logic [DATA_W-1:0]     ram_mem [0:RAM_DEPTH-1];
  logic                  strobe;
  logic                  selected;
  logic                  start;
  logic [ADDR_W-1:0]     host_addr;
  logic                  host_ram;
  logic                  ram_we;
  logic [ADDR_W-1:0]     ram_waddr;
  logic [DATA_W-1:0]     ram_wdata;
  logic                  sync_fam0;

  if (ADDR_W != 11 || DATA_W != 8 || RAM_DEPTH != 2048) begin : g_bad_geometry
    $error("Unsupported bus geometry");
  end

  // ==========================================================
  // Access detection and address path
  always_comb begin
    sync_fam0 = (sync_reg == TIMING_SYNC) && (mot_reg != FAMILY_MOT);
    strobe    = strobe_on(mot_reg, read_or_direction_in, write_or_strobe_in);
    if (sync_fam0) begin
      selected  = (latch_reg[DEC_HI:DEC_LO] == 5'h00);
      host_addr = {address_bus_in[ADDR_W-1:8], latch_reg};
    end else begin
      selected  = !chip_select_n;
      host_addr = address_bus_in;
    end
    if (mot_reg == FAMILY_MOT && host_addr >= SWAP_LO && host_addr <= SWAP_HI) begin
      host_addr[0] = !host_addr[0];
    end
    start = (state_reg == ST_IDLE) && strobe && selected;
  end

  // ==========================================================
  // Access sequencing and RAM arbitration
  always_comb begin
    state_next     = state_reg;
    latch_next     = latch_reg;
    addr_next      = addr_reg;
    rd_next        = rd_reg;
    wdata_next     = wdata_reg;
    dout_next      = data_bus_io_out;
    oe_next        = data_bus_io_oe;
    rdy_next       = host_ready_out;
    ack_next       = transfer_ack_out;
    seq_rdata_next = seq_rdata;
    seq_done_next  = 1'b0;
    host_ram       = 1'b0;
    ram_we         = 1'b0;
    ram_waddr      = addr_reg;
    ram_wdata      = wdata_reg;
    if (sync_fam0 && addr_latch_strobe) begin
      latch_next = data_bus_io_in;
    end
    case (state_reg)
      ST_IDLE: begin
        rdy_next = 1'b0;
        ack_next = 1'b0;
        oe_next  = 1'b0;
        if (start) begin
          addr_next  = host_addr;
          rd_next    = is_read(mot_reg, read_or_direction_in);
          wdata_next = data_bus_io_in;
          state_next = ST_RAM;
        end
      end
      ST_RAM: begin
        host_ram = 1'b1;
        if (rd_reg) begin
          dout_next = ram_mem[addr_reg];
          oe_next   = 1'b1;
        end else begin
          ram_we = 1'b1;
        end
        if (sync_reg != TIMING_SYNC) begin
          rdy_next = (mot_reg != FAMILY_MOT);
          ack_next = (mot_reg == FAMILY_MOT);
        end
        state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (!strobe) begin
          rdy_next   = 1'b0;
          ack_next   = 1'b0;
          oe_next    = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (seq_req && !host_ram) begin
      seq_done_next = 1'b1;
      if (seq_we) begin
        ram_we    = 1'b1;
        ram_waddr = seq_addr;
        ram_wdata = seq_wdata;
      end else begin
        seq_rdata_next = ram_mem[seq_addr];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mot_reg          <= host_family_select;
      sync_reg         <= timing_mode_select;
      state_reg        <= ST_IDLE;
      latch_reg        <= LATCH_RST;
      addr_reg         <= ADDR_RST;
      rd_reg           <= 1'b0;
      wdata_reg        <= DOUT_RST;
      data_bus_io_out  <= DOUT_RST;
      data_bus_io_oe   <= 1'b0;
      host_ready_out   <= 1'b0;
      transfer_ack_out <= 1'b0;
      seq_rdata        <= DOUT_RST;
      seq_done         <= 1'b0;
    end else begin
      state_reg        <= state_next;
      latch_reg        <= latch_next;
      addr_reg         <= addr_next;
      rd_reg           <= rd_next;
      wdata_reg        <= wdata_next;
      data_bus_io_out  <= dout_next;
      data_bus_io_oe   <= oe_next;
      host_ready_out   <= rdy_next;
      transfer_ack_out <= ack_next;
      seq_rdata        <= seq_rdata_next;
      seq_done         <= seq_done_next;
    end
  end

  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_mem[ram_waddr] <= ram_wdata;
    end
  end

  // ==========================================================
  // Divided clock
  clock_scaler u_scaler (
    .clk        (clk),
    .rst_b      (rst_b),
    .div_by_two (divider_select),
    .clk_out    (divided_clock_out)
  );

  // ==========================================================
  // Checks
  sequence access_begins;
    start;
  endsequence

  sequence access_served;
    (state_reg == ST_RAM) ##1 (state_reg == ST_HOLD);
  endsequence

  sync_no_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sync_reg == TIMING_SYNC) |-> (!host_ready_out && !transfer_ack_out))
    else $error("Ready driven in synchronous mode");

  mot_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    (mot_reg == FAMILY_MOT && sync_reg != TIMING_SYNC) ##0 access_begins |-> ##2 transfer_ack_out)
    else $error("Acknowledge missing in async mode");

  fam0_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
    (mot_reg != FAMILY_MOT && sync_reg != TIMING_SYNC) ##0 access_begins
    |-> ##1 access_served ##0 host_ready_out && !transfer_ack_out)
    else $error("Ready missing in async mode");

  ready_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    access_begins |=> !host_ready_out && !transfer_ack_out)
    else $error("Ready raised before data");

  cs_needed_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!sync_fam0 && chip_select_n) |-> !start)
    else $error("Access without chip select");

  decoder_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sync_fam0 && start) |-> (latch_reg[DEC_HI:DEC_LO] == 5'h00))
    else $error("Decoder selected wrong address");

  latch_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sync_fam0 && addr_latch_strobe) |=> (latch_reg == $past(data_bus_io_in)))
    else $error("Address latch not loaded");

  swap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (mot_reg == FAMILY_MOT && start && address_bus_in <= SWAP_HI)
    |=> (addr_reg == ($past(address_bus_in) ^ 11'h001)))
    else $error("Byte swap missing");

  priority_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_RAM && seq_req) |=> !seq_done)
    else $error("Sequencer served over host");

  div_a: assert property (@(posedge clk) disable iff (!rst_b)
    divider_select [*3] |-> (divided_clock_out != $past(divided_clock_out)))
    else $error("Divide by two wrong");
endmodule
`default_nettype wire

// [logic/host_bus_pkg.sv]
package host_bus_pkg;
  localparam int          ADDR_W       = 11;
  localparam int          DATA_W       = 8;
  localparam int          RAM_DEPTH    = 2048;
  localparam logic        FAMILY_MOT   = 1'b1;
  localparam logic        TIMING_SYNC  = 1'b1;
  localparam logic        DIV_BY_TWO   = 1'b1;
  localparam int          DIV_CNT_W    = 2;
  localparam int          DEC_HI       = 7;
  localparam int          DEC_LO       = 3;
  localparam logic [10:0] SWAP_LO      = 11'h000;
  localparam logic [10:0] SWAP_HI      = 11'h007;
  localparam logic [7:0]  LATCH_RST    = 8'h00;
  localparam logic [7:0]  DOUT_RST     = 8'h00;
  localparam logic [10:0] ADDR_RST     = 11'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAM  = 2'b01,
    ST_HOLD = 2'b10
  } bus_state_t;
endpackage

// [logic/clock_scaler.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_scaler (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic div_by_two,
  output var  logic clk_out
);
  import host_bus_pkg::*;

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic                 out_next;

  always_comb begin
    cnt_next = cnt_reg + 2'h1;
    out_next = (div_by_two == DIV_BY_TWO) ? cnt_next[0] : cnt_next[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_reg <= 2'h0;
      clk_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_out <= out_next;
    end
  end
endmodule
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic                            clk,
  input  wire logic                            fam,
  input  wire logic                            sync,
  input  wire logic [host_bus_pkg::DATA_W-1:0] dut_q,
  input  wire logic                            dut_oe,
  input  wire logic                            rdy,
  input  wire logic                            ack,
  output var  logic                            cs_n,
  output var  logic [host_bus_pkg::ADDR_W-1:0] addr,
  output var  logic                            ale,
  output var  logic                            rw,
  output var  logic                            strb,
  output var  logic [host_bus_pkg::DATA_W-1:0] pin
);
  import host_bus_pkg::*;
  logic [DATA_W-1:0] host_d;
  logic [DATA_W-1:0] last_v;
  logic              host_drv;
  // Released bus shows the inverse of its last level
  assign pin = host_drv ? host_d : (dut_oe ? dut_q : ~last_v);
  always @(posedge clk) begin
    if (host_drv || dut_oe) last_v <= pin;
  end
  initial begin
    cs_n = 1'h1; addr = '0; ale = 1'h0; rw = 1'h1; strb = 1'h1;
    host_d = '0; host_drv = 1'h0; last_v = '0;
  end
  task idle;
    cs_n <= 1'h1;
    ale <= 1'h0;
    host_drv <= 1'h0;
    rw <= 1'h1;
    strb <= ~fam;
  endtask
  task xfer(input logic we, input logic sel, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
            output logic [DATA_W-1:0] rd, output logic got);
    rd = '0;
    got = 1'h0;
    if (!fam && sync) begin
      @(posedge clk);
      ale <= 1'h1;
      host_drv <= 1'h1;
      host_d <= a[7:0];
      @(posedge clk);
      ale <= 1'h0;
      host_drv <= 1'h0;
    end
    @(posedge clk);
    cs_n <= (sync && !fam) ? 1'h1 : ~sel;
    addr <= a;
    host_drv <= we;
    host_d <= wd;
    rw <= fam ? ~we : we;
    strb <= fam ? 1'h1 : ~we;
    for (int n = 1; n <= 8; n++) begin
      @(posedge clk);
      if (sync ? (n == 3) : (fam ? ack : rdy)) begin
        got = 1'h1;
        rd = pin;
        break;
      end
    end
    idle();
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import host_bus_pkg::*;
  logic clk, rst_b, fam, sync, div_sel, sreq, swe, sdone, oe, rdy, ack, dclk;
  logic cs_n, ale, rw, strb, got, oe_seen, hs_seen;
  logic [ADDR_W-1:0] addr, saddr;
  logic [DATA_W-1:0] pin, q, swd, srd, rd;
  int err_total, checks_done, cyc;
  host_bus_interface_config host_bus_interface_config_inst (
    .clk(clk), .rst_b(rst_b), .host_family_select(fam), .timing_mode_select(sync),
    .divider_select(div_sel), .chip_select_n(cs_n), .address_bus_in(addr), .addr_latch_strobe(ale),
    .read_or_direction_in(rw), .write_or_strobe_in(strb), .data_bus_io_in(pin), .data_bus_io_out(q),
    .data_bus_io_oe(oe), .host_ready_out(rdy), .transfer_ack_out(ack), .divided_clock_out(dclk),
    .seq_req(sreq), .seq_we(swe), .seq_addr(saddr), .seq_wdata(swd), .seq_rdata(srd), .seq_done(sdone));
  host_model host_model_inst (
    .clk(clk), .fam(fam), .sync(sync), .dut_q(q), .dut_oe(oe), .rdy(rdy), .ack(ack), .cs_n(cs_n),
    .addr(addr), .ale(ale), .rw(rw), .strb(strb), .pin(pin));
  initial clk = 1'h0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (oe) oe_seen <= 1'h1;
    if (rdy || ack) hs_seen <= 1'h1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      conclude();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task set_mode(input logic f, input logic s);
    @(posedge clk);
    rst_b <= 1'h0;
    fam <= f;
    sync <= s;
    repeat (3) @(posedge clk);
    host_model_inst.idle();
    @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    oe_seen = 1'h0;
    hs_seen = 1'h0;
  endtask
  task wr_rd(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    host_model_inst.xfer(1'h1, 1'h1, a, d, rd, got);
    host_model_inst.xfer(1'h0, 1'h1, a, 8'h00, rd, got);
    check(rd, d);
  endtask
  task t_async_zero;
    set_mode(1'h0, 1'h0);
    wr_rd(11'h123, 8'hA5);
    check({7'h00, hs_seen}, 8'h01);
    host_model_inst.xfer(1'h0, 1'h0, 11'h123, 8'h00, rd, got);
    check({7'h00, got}, 8'h00);
    $display("async family zero done");
  endtask
  task t_shared_ram;
    fork
      host_model_inst.xfer(1'h0, 1'h1, 11'h123, 8'h00, rd, got);
      begin
        @(posedge clk);
        sreq <= 1'h1;
        swe <= 1'h1;
        saddr <= 11'h124;
        swd <= 8'hC3;
        repeat (6) @(posedge clk);
        sreq <= 1'h0;
        swe <= 1'h0;
      end
    join
    check(rd, 8'hA5);
    host_model_inst.xfer(1'h0, 1'h1, 11'h124, 8'h00, rd, got);
    check(rd, 8'hC3);
    $display("shared ram done");
  endtask
  task t_async_one;
    set_mode(1'h1, 1'h0);
    host_model_inst.xfer(1'h1, 1'h1, 11'h000, 8'h3C, rd, got);
    check({7'h00, got}, 8'h01);
    @(posedge clk);
    sreq <= 1'h1;
    saddr <= 11'h001;
    for (int n = 0; n < 8 && !sdone; n++) @(posedge clk);
    check(srd, 8'h3C);
    sreq <= 1'h0;
    wr_rd(11'h040, 8'h5A);
    host_model_inst.xfer(1'h0, 1'h0, 11'h040, 8'h00, rd, got);
    check({7'h00, got}, 8'h00);
    $display("async family one done");
  endtask
  task t_sync_zero;
    set_mode(1'h0, 1'h1);
    wr_rd(11'h305, 8'h77);
    check({7'h00, hs_seen}, 8'h00);
    @(posedge clk);
    oe_seen = 1'h0;
    host_model_inst.xfer(1'h0, 1'h1, 11'h008, 8'h00, rd, got);
    check({7'h00, oe_seen}, 8'h00);
    $display("sync family zero done");
  endtask
  task t_sync_one;
    set_mode(1'h1, 1'h1);
    div_sel <= 1'h0;
    wr_rd(11'h222, 8'hAB);
    check({7'h00, hs_seen}, 8'h00);
    $display("sync family one done");
  endtask
  task t_divider(input logic sel, input logic [7:0] exp);
    logic prev;
    logic [7:0] flips;
    @(posedge clk);
    div_sel <= sel;
    repeat (8) @(posedge clk);
    prev = dclk;
    flips = 8'h00;
    repeat (40) begin
      @(posedge clk);
      if (dclk !== prev) flips++;
      prev = dclk;
    end
    check(flips, exp);
    $display("divider test done");
  endtask
  initial begin
    rst_b = 1'h0; fam = 1'h0; sync = 1'h0; div_sel = 1'h1; sreq = 1'h0; swe = 1'h0;
    saddr = '0; swd = 8'h00; err_total = 0; checks_done = 0; cyc = 0;
    oe_seen = 1'h0; hs_seen = 1'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    t_async_zero();
    t_shared_ram();
    t_async_one();
    t_sync_zero();
    t_sync_one();
    t_divider(1'h1, 8'h28);
    t_divider(1'h0, 8'h14);
    conclude();
  end
endmodule
`default_nettype wire
